// *** design/ars_axil_slave.sv ***
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: bank answers hit and read data combinationally
// Notes: unmapped address answers DECERR
`timescale 1ns/1ps
module ars_axil_slave
  import ars_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and data
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // bank side
  ars_reg_if.slave rb
);
  logic aw_ok_r;
  logic w_ok_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_ok_r & w_ok_r & ~bvalid_r;
  wire ar_take = s_axi_arvalid & s_axi_arready;

  assign s_axi_awready = ~aw_ok_r;
  assign s_axi_wready = ~w_ok_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign rb.wr_en = wr_fire;
  assign rb.wr_addr = awaddr_r;
  assign rb.wr_data = wdata_r;
  assign rb.wr_strb = wstrb_r;
  assign rb.rd_en = ar_take;
  assign rb.rd_addr = s_axi_araddr;

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= ARS_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_ok_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_ok_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= rb.wr_hit ? ARS_RESP_OKAY : ARS_RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= ARS_RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rresp_r <= rb.rd_hit ? ARS_RESP_OKAY : ARS_RESP_DECERR;
      rdata_r <= rb.rd_data;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule // ars_axil_slave

// *** design/ars_irq.sv ***
// Purpose: sticky event status, mask and level interrupt
// Assumes: events are one-cycle pulses on aclk
// Notes: read clears status; an event in the clearing cycle survives
`timescale 1ns/1ps
module ars_irq
  import ars_pkg::*;
#(
  parameter int N = ARS_EVT_N
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // events and software access
  input wire logic [N-1:0] evt,
  input wire logic stat_rd,
  input wire logic mask_wr,
  input wire logic [N-1:0] mask_wdata,
  // state
  output logic [N-1:0] stat,
  output logic [N-1:0] mask,
  output logic irq
);
  logic [N-1:0] stat_r;
  logic [N-1:0] mask_r;
  wire [N-1:0] stat_nxt = (stat_rd ? '0 : stat_r) | evt;

  assign stat = stat_r;
  assign mask = mask_r;
  assign irq = |(stat_r & mask_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= '0;
      mask_r <= N'(ARS_MASK_RST);
    end else begin
      stat_r <= stat_nxt;
      if (mask_wr) begin
        mask_r <= mask_wdata;
      end
    end
  end
endmodule // ars_irq

// *** design/ars_pkg.sv ***
// Purpose: shared constants for the autonegotiation result status bank
// Assumes: 32-bit AXI4-Lite register bus, word per register
// Notes: printed offsets are register indexes; byte address is 4x index
package ars_pkg;
  // register indexes, register width and event count
  localparam logic [15:0] ARS_RES_IDX = 16'h8001;
  localparam logic [15:0] ARS_LIVE_IDX = 16'h8030;
  localparam logic [15:0] ARS_IRQ_STAT_IDX = 16'h8040;
  localparam logic [15:0] ARS_IRQ_MASK_IDX = 16'h8041;
  localparam int ARS_REG_W = 16;
  localparam int ARS_EVT_N = 3;
  // result register fields
  localparam int ARS_NP_BIT = 10;
  localparam int ARS_INC_BIT = 9;
  localparam int ARS_TXL_LSB = 7;
  localparam int ARS_ROLE_LSB = 5;
  localparam int ARS_HCD_LSB = 1;
  localparam int ARS_DONE_BIT = 0;
  // live register fields
  localparam int ARS_LV_ARB_BIT = 4;
  localparam int ARS_LV_LEAD_BIT = 3;
  localparam int ARS_LV_FOLL_BIT = 2;
  localparam int ARS_LV_HI_BIT = 1;
  localparam int ARS_LV_LO_BIT = 0;
  // field codes
  localparam logic [1:0] ARS_TXL_NONE = 2'h0;
  localparam logic [1:0] ARS_TXL_LOW = 2'h2;
  localparam logic [1:0] ARS_TXL_HIGH = 2'h3;
  localparam logic [1:0] ARS_ROLE_NONE = 2'h0;
  localparam logic [1:0] ARS_ROLE_FAULT = 2'h1;
  localparam logic [1:0] ARS_ROLE_FOLL = 2'h2;
  localparam logic [1:0] ARS_ROLE_LEAD = 2'h3;
  localparam logic [3:0] ARS_HCD_NULL = 4'h0;
  localparam logic [3:0] ARS_HCD_T1L = 4'h1;
  // reset values
  localparam logic [15:0] ARS_RES_RST = 16'h0000;
  localparam logic [15:0] ARS_LIVE_RST = 16'h0010;
  localparam logic [2:0] ARS_MASK_RST = 3'h0;
  // event bits in interrupt status
  localparam int ARS_EV_NP = 0;
  localparam int ARS_EV_GCHK = 1;
  localparam int ARS_EV_DONE = 2;
  // bus responses
  localparam logic [1:0] ARS_RESP_OKAY = 2'h0;
  localparam logic [1:0] ARS_RESP_DECERR = 2'h3;

  function automatic logic [31:0] ars_byte_addr(input logic [15:0] idx);
    ars_byte_addr = {14'h0000, idx, 2'b00};
  endfunction
endpackage

// *** design/ars_reg_if.sv ***
// Purpose: register access strobes between bus slave and register bank
// Assumes: single clock
// Notes: strobes are one-cycle pulses
`timescale 1ns/1ps
interface ars_reg_if;
  logic wr_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic rd_en;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_hit, rd_data, rd_hit);
  modport bank (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_hit, rd_data, rd_hit);
endinterface // ars_reg_if

// *** design/ars_top.sv ***
// Purpose: autonegotiation result and live status registers
// Assumes: engine inputs come from logic on aclk, no synchronisers
// Notes: result and live registers ignore writes
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ars_top
  import ars_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // arbitration engine events
  input wire logic partner_next_page_seen,
  input wire logic good_check_entry,
  input wire logic incompatible_result,
  // resolution outcomes
  input wire logic tx_res_done,
  input wire logic tx_res_high,
  input wire logic role_res_done,
  input wire logic role_res_fault,
  input wire logic role_res_leader,
  input wire logic tech_res_done,
  input wire logic tech_res_t1l,
  input wire logic negotiation_done_flag,
  // instantaneous engine state
  input wire logic arbitration_drives_tx,
  input wire logic arb_in_good_check,
  input wire logic arb_in_good,
  input wire logic link_control_enable_bit,
  input wire logic phy_is_leader,
  input wire logic phy_tx_active,
  input wire logic tx_amplitude_sel_high,
  // interrupt
  output logic irq
);
  ars_reg_if rb ();

  // result and live register state
  logic np_r;
  logic inc_r;
  logic [1:0] txl_r;
  logic [1:0] role_r;
  logic [3:0] hcd_r;
  logic done_r;
  logic [15:0] live_r;
  logic [15:0] live_nxt;
  logic [1:0] txl_nxt;
  logic [1:0] role_nxt;
  logic [3:0] hcd_nxt;
  logic done_d_r;

  // address decode
  wire hit_res_rd = rb.rd_addr == ars_byte_addr(ARS_RES_IDX);
  wire hit_live_rd = rb.rd_addr == ars_byte_addr(ARS_LIVE_IDX);
  wire hit_stat_rd = rb.rd_addr == ars_byte_addr(ARS_IRQ_STAT_IDX);
  wire hit_mask_rd = rb.rd_addr == ars_byte_addr(ARS_IRQ_MASK_IDX);
  wire hit_res_wr = rb.wr_addr == ars_byte_addr(ARS_RES_IDX);
  wire hit_live_wr = rb.wr_addr == ars_byte_addr(ARS_LIVE_IDX);
  wire hit_stat_wr = rb.wr_addr == ars_byte_addr(ARS_IRQ_STAT_IDX);
  wire hit_mask_wr = rb.wr_addr == ars_byte_addr(ARS_IRQ_MASK_IDX);
  wire res_rd = rb.rd_en & hit_res_rd;
  wire stat_rd = rb.rd_en & hit_stat_rd;
  wire mask_wr = rb.wr_en & hit_mask_wr & rb.wr_strb[0];
  wire [ARS_EVT_N-1:0] irq_stat;
  wire [ARS_EVT_N-1:0] irq_mask;
  wire [ARS_EVT_N-1:0] evt;

  // result register image, reserved bits zero
  wire [15:0] res_word = {5'h00, np_r, inc_r, txl_r, role_r, hcd_r,
    done_r};

  assign rb.rd_hit = hit_res_rd | hit_live_rd | hit_stat_rd | hit_mask_rd;
  assign rb.wr_hit = hit_res_wr | hit_live_wr | hit_stat_wr | hit_mask_wr;

  // read data select; writes to result and live fall through untouched
  assign rb.rd_data = hit_res_rd ? {16'h0000, res_word} :
    hit_live_rd ? {16'h0000, live_r} :
    hit_stat_rd ? {29'h00000000, irq_stat} :
    hit_mask_rd ? {29'h00000000, irq_mask} :
    32'h00000000;

  // field encoders
  always_comb begin
    txl_nxt = ARS_TXL_NONE;
    if (tx_res_done) begin
      txl_nxt = tx_res_high ? ARS_TXL_HIGH : ARS_TXL_LOW;
    end
  end

  always_comb begin
    role_nxt = ARS_ROLE_NONE;
    if (role_res_done) begin
      if (role_res_fault) begin
        role_nxt = ARS_ROLE_FAULT;
      end else if (role_res_leader) begin
        role_nxt = ARS_ROLE_LEAD;
      end else begin
        role_nxt = ARS_ROLE_FOLL;
      end
    end
  end

  always_comb begin
    hcd_nxt = ARS_HCD_NULL;
    if (tech_res_done && tech_res_t1l) begin
      hcd_nxt = ARS_HCD_T1L;
    end
  end

  // live snapshot, one word sampled per edge
  always_comb begin
    live_nxt = 16'h0000;
    live_nxt[ARS_LV_ARB_BIT] = arbitration_drives_tx & ~arb_in_good_check &
      ~arb_in_good;
    live_nxt[ARS_LV_LEAD_BIT] = link_control_enable_bit &
      phy_is_leader;
    live_nxt[ARS_LV_FOLL_BIT] = link_control_enable_bit &
      ~phy_is_leader;
    live_nxt[ARS_LV_HI_BIT] = phy_tx_active & tx_amplitude_sel_high;
    live_nxt[ARS_LV_LO_BIT] = phy_tx_active & ~tx_amplitude_sel_high;
  end

  // next page latch, set beats read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      np_r <= ARS_RES_RST[ARS_NP_BIT];
    end else if (partner_next_page_seen) begin
      np_r <= 1'b1;
    end else if (res_rd) begin
      np_r <= 1'b0;
    end
  end

  // incompatible link, sampled on good-check entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inc_r <= ARS_RES_RST[ARS_INC_BIT];
    end else if (good_check_entry) begin
      inc_r <= incompatible_result;
    end
  end

  // resolved fields follow the engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txl_r <= ARS_RES_RST[ARS_TXL_LSB +: 2];
      role_r <= ARS_RES_RST[ARS_ROLE_LSB +: 2];
      hcd_r <= ARS_RES_RST[ARS_HCD_LSB +: 4];
      done_r <= ARS_RES_RST[ARS_DONE_BIT];
      done_d_r <= 1'b0;
    end else begin
      txl_r <= txl_nxt;
      role_r <= role_nxt;
      hcd_r <= hcd_nxt;
      done_r <= negotiation_done_flag;
      done_d_r <= done_r;
    end
  end

  // live register, never latched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      live_r <= ARS_LIVE_RST;
    end else begin
      live_r <= live_nxt;
    end
  end

  // interrupt events
  assign evt[ARS_EV_NP] = partner_next_page_seen;
  assign evt[ARS_EV_GCHK] = good_check_entry;
  assign evt[ARS_EV_DONE] = done_r & ~done_d_r;

  ars_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rb(rb.slave)
  );

  ars_irq #(
    .N(ARS_EVT_N)
  ) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .evt(evt),
    .stat_rd(stat_rd),
    .mask_wr(mask_wr),
    .mask_wdata(rb.wr_data[ARS_EVT_N-1:0]),
    .stat(irq_stat),
    .mask(irq_mask),
    .irq(irq)
  );
endmodule // ars_top

// *** testbench/ars_host_model.sv ***
// Purpose: management host model, axi4-lite master
// Assumes: one transfer at a time, driven after rising edges
// Notes: dly stalls bready and rready to get slow answers
`timescale 1ns/1ps
module ars_host_model (
  // clock
  input wire logic aclk,
  // write
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int dly = 0;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
  end
  task automatic wr(input logic [31:0] a, dt, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    repeat (dly) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] dt,
    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (dly) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    dt = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule // ars_host_model

// *** testbench/ars_top_properties.sv ***
// Purpose: port checks for ars_top
// Assumes: one clock, synchronous low reset
// Notes: register fields lag the engine inputs by one edge
`timescale 1ns/1ps
module ars_top_chk
  import ars_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // engine
  input wire logic partner_next_page_seen,
  input wire logic tx_res_done,
  input wire logic tx_res_high,
  input wire logic arbitration_drives_tx,
  input wire logic arb_in_good_check,
  input wire logic arb_in_good,
  input wire logic link_control_enable_bit,
  input wire logic phy_is_leader,
  input wire logic phy_tx_active,
  input wire logic tx_amplitude_sel_high
);
  localparam logic [31:0] RA = {14'h0, ARS_RES_IDX, 2'h0};
  localparam logic [31:0] LA = {14'h0, ARS_LIVE_IDX, 2'h0};
  wire logic [1:0] txl = !tx_res_done ? ARS_TXL_NONE :
    tx_res_high ? ARS_TXL_HIGH : ARS_TXL_LOW;
  wire logic arb = arbitration_drives_tx & ~arb_in_good_check & ~arb_in_good;
  wire logic [1:0] lr = {2{link_control_enable_bit}} &
    {phy_is_leader, ~phy_is_leader};
  wire logic [1:0] amp = {2{phy_tx_active}} &
    {tx_amplitude_sel_high, ~tx_amplitude_sel_high};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence res_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == RA && $past(aresetn);
  endsequence
  sequence live_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == LA && $past(aresetn);
  endsequence
  AST_AR_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_NP_SEEN: assert property (
    res_rd ##0 $past(partner_next_page_seen) |=> s_axi_rdata[10])
    else $error("next page flag missing");
  AST_TXL: assert property (
    res_rd |=> s_axi_rdata[8:7] == $past(txl, 2))
    else $error("level field wrong");
  AST_LIVE_ARB: assert property (
    live_rd |=> s_axi_rdata[4] == $past(arb, 2))
    else $error("live arbitration bit wrong");
  AST_LIVE_ROLE: assert property (
    live_rd |=> s_axi_rdata[3:2] == $past(lr, 2))
    else $error("live role bits wrong");
  AST_LIVE_AMP: assert property (
    live_rd |=> s_axi_rdata[1:0] == $past(amp, 2))
    else $error("live amplitude bits wrong");
  AST_RSVD: assert property (
    s_axi_rvalid && s_axi_rresp == ARS_RESP_OKAY |-> s_axi_rdata[31:16] == 0)
    else $error("upper bits not zero");
endmodule // ars_top_chk

bind ars_top ars_top_chk chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bvalid, .s_axi_bready, .partner_next_page_seen, .tx_res_done,
  .tx_res_high, .arbitration_drives_tx, .arb_in_good_check, .arb_in_good,
  .link_control_enable_bit, .phy_is_leader, .phy_tx_active,
  .tx_amplitude_sel_high);

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench for ars_top
// Assumes: ars_host_model drives the bus
// Notes: engine inputs packed in e, random from a fixed seed
`timescale 1ns/1ps
module tb_top;
  import ars_pkg::*;
  localparam logic [31:0] RA = {14'h0, ARS_RES_IDX, 2'h0};
  localparam logic [31:0] LA = {14'h0, ARS_LIVE_IDX, 2'h0};
  localparam logic [31:0] SA = {14'h0, ARS_IRQ_STAT_IDX, 2'h0};
  localparam logic [31:0] MA = {14'h0, ARS_IRQ_MASK_IDX, 2'h0};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [17:0] e = 18'h00800;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, irq;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic inc_m = 1'b0;
  logic [31:0] st = 32'h3EF818A2;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  always #2 aclk = ~aclk;
  ars_host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ars_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .partner_next_page_seen(e[0]), .good_check_entry(e[1]),
    .incompatible_result(e[2]), .tx_res_done(e[3]), .tx_res_high(e[4]),
    .role_res_done(e[5]), .role_res_fault(e[6]), .role_res_leader(e[7]),
    .tech_res_done(e[8]), .tech_res_t1l(e[9]),
    .negotiation_done_flag(e[10]), .arbitration_drives_tx(e[11]),
    .arb_in_good_check(e[12]), .arb_in_good(e[13]),
    .link_control_enable_bit(e[14]), .phy_is_leader(e[15]),
    .phy_tx_active(e[16]), .tx_amplitude_sel_high(e[17]), .irq);
  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  function automatic logic [31:0] fres(input logic [17:0] x, input logic i);
    logic [1:0] t, o;
    t = !x[3] ? ARS_TXL_NONE : x[4] ? ARS_TXL_HIGH : ARS_TXL_LOW;
    o = !x[5] ? ARS_ROLE_NONE : x[6] ? ARS_ROLE_FAULT :
      x[7] ? ARS_ROLE_LEAD : ARS_ROLE_FOLL;
    return {22'h0, i, t, o, (x[8] & x[9]) ? ARS_HCD_T1L : ARS_HCD_NULL, x[10]};
  endfunction
  function automatic logic [31:0] flive(input logic [17:0] x);
    return {27'h0, x[11] & ~x[12] & ~x[13], x[14] & x[15], x[14] & ~x[15],
      x[16] & x[17], x[16] & ~x[17]};
  endfunction
  task automatic chk(input string n, input logic [31:0] ex, got);
    checked++;
    if (got !== ex) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic rdc(input logic [31:0] a, ex, input string n);
    host.rd(a, d, r);
    chk(n, ex, d);
  endtask
  task automatic pulse(input int i);
    @(posedge aclk);
    e[i] <= 1'b1;
    @(posedge aclk);
    e[i] <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("counts checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(RA, 32'h0, "result");
    rdc(LA, 32'h10, "live");
    rdc(SA, 32'h0, "status");
    rdc(MA, 32'h0, "mask");
    $display("test reset ends");
    host.wr(RA, 32'hFFFF, r);
    chk("wr resp", {30'h0, ARS_RESP_OKAY}, {30'h0, r});
    host.wr(LA, 32'hFFFF, r);
    chk("wr resp", {30'h0, ARS_RESP_OKAY}, {30'h0, r});
    rdc(RA, 32'h0, "result");
    rdc(LA, 32'h10, "live");
    host.wr(32'h0, 32'h7, r);
    chk("bad wr", {30'h0, ARS_RESP_DECERR}, {30'h0, r});
    host.rd(32'h10, d, r);
    chk("bad rd", {30'h0, ARS_RESP_DECERR}, {30'h0, r});
    $display("test writes ends");
    host.wr(MA, 32'h7, r);
    rdc(MA, 32'h7, "mask");
    pulse(0);
    @(posedge aclk);
    e[10] <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("irq", 32'h1, {31'h0, irq});
    rdc(RA, 32'h400 | fres(e, inc_m), "result");
    rdc(RA, fres(e, inc_m), "result");
    rdc(SA, 32'h5, "status");
    @(negedge aclk);
    chk("irq", 32'h0, {31'h0, irq});
    host.wr(MA, 32'h0, r);
    e[2] <= 1'b1;
    pulse(1);
    inc_m = 1'b1;
    @(negedge aclk);
    chk("irq", 32'h0, {31'h0, irq});
    rdc(SA, 32'h2, "status");
    rdc(RA, fres(e, inc_m), "result");
    e[2] <= 1'b0;
    rdc(RA, fres(e, inc_m), "result");
    pulse(1);
    inc_m = 1'b0;
    rdc(RA, fres(e, inc_m), "result");
    e[0] <= 1'b1;
    fork
      rdc(RA, 32'h400 | fres(e, inc_m), "result");
      begin
        repeat (2) @(posedge aclk);
        e[0] <= 1'b0;
      end
    join
    rdc(RA, 32'h400 | fres(e, inc_m), "result");
    rdc(RA, fres(e, inc_m), "result");
    $display("test events ends");
    for (int i = 0; i < 60; i++) begin
      host.dly = int'(rnd() % 32'h3);
      e <= 18'(rnd()) & 18'h3FFFC;
      host.wr(RA, rnd(), r);
      chk("wr resp", {30'h0, ARS_RESP_OKAY}, {30'h0, r});
      repeat (2) @(posedge aclk);
      rdc(RA, fres(e, inc_m), "result");
      rdc(LA, flive(e), "live");
    end
    $display("test random ends");
    give_verdict();
  end
endmodule // tb_top
